//--- hdl/ctrl_port_pkg.sv
// Purpose: constants and types for the dual mode control port
// Assumes: 7-bit register space, 8-bit registers
// Notes: pin indices address the synchroniser vector
package ctrl_port_pkg;
    localparam logic [6:0] SPI_CHIP_ADDR = 7'h10;
    localparam logic [3:0] I2C_ADDR_UPPER = 4'h2;
    localparam int PTR_STEP_BIT = 7;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // synchroniser vector bit positions
    localparam int P_SEL = 0;
    localparam int P_CLK = 1;
    localparam int P_DIN = 2;
    localparam int P_SDA = 3;
    localparam int P_AD1 = 4;
    localparam int P_EMPHASIS_STRAP_PIN = 5;
    localparam int N_PINS = 6;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [6:0] REG_GENERAL = 7'h01;
    localparam logic [6:0] REG_MONO = 7'h02;
    localparam logic [6:0] REG_ROUTING = 7'h03;
    localparam logic [6:0] REG_CLKSRC = 7'h04;
    localparam logic [6:0] REG_SIN_FMT = 7'h05;
    localparam logic [6:0] REG_SOUT_FMT = 7'h06;
    localparam logic [6:0] REG_STA_A = 7'h07;
    localparam logic [6:0] REG_STA_B = 7'h08;
    localparam logic [6:0] REG_MASK_A = 7'h09;
    localparam logic [6:0] REG_MODE_HI_A = 7'h0A;
    localparam logic [6:0] REG_MODE_LO_A = 7'h0B;
    localparam logic [6:0] REG_MASK_B = 7'h0C;
    localparam logic [6:0] REG_MODE_HI_B = 7'h0D;
    localparam logic [6:0] REG_MODE_LO_B = 7'h0E;
    localparam logic [6:0] REG_RX_CS = 7'h0F;
    localparam logic [6:0] REG_RX_ERR = 7'h10;
    localparam logic [6:0] REG_RX_ERR_MASK = 7'h11;
    localparam logic [6:0] REG_CS_BUF_CTL = 7'h12;
    localparam logic [6:0] REG_U_BUF_CTL = 7'h13;
    localparam logic [6:0] REG_SUBCODE_FIRST = 7'h14;
    localparam logic [6:0] REG_SUBCODE_LAST = 7'h1D;
    localparam logic [6:0] REG_CLK_RATIO = 7'h1E;
    localparam logic [6:0] REG_BUF_FIRST = 7'h20;
    localparam logic [6:0] REG_BUF_LAST = 7'h37;
    localparam logic [6:0] REG_IDENTITY = 7'h7F;
    localparam logic [7:0] WM_GENERAL = 8'hF7;
    localparam logic [7:0] WM_SEVEN = 8'h7F;
    localparam logic [7:0] WM_ROUTING = 8'h7E;
    localparam logic [7:0] WM_FULL = 8'hFF;
    localparam logic [7:0] WM_IRQ_A = 8'hC7;
    localparam logic [7:0] WM_IRQ_B = 8'h0E;
    localparam logic [7:0] WM_CS_BUF = 8'h3F;
    localparam logic [7:0] WM_U_BUF = 8'h1F;
    localparam logic [7:0] RST_ROUTING = 8'h0C;
    localparam int STYLE_LSB = 1;
    localparam logic [1:0] STYLE_HIGH = 2'b00;
    localparam logic [1:0] STYLE_LOW = 2'b01;
    localparam logic [1:0] STYLE_OPEN = 2'b10;
    typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_IGNORE} state_t;
endpackage

//--- hdl/dual_mode_control_port.sv
// Purpose: SPI or I2C slave port onto the configuration registers
// Assumes: pins sampled by mclk_i, host clock far below mclk_i
// Notes: irq sources and readback inputs are on mclk_i already
`timescale 1ns/1ps
module dual_mode_control_port #(
    parameter logic [7:0] ID_VALUE = 8'h5A // arbitrary value
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic mode_strap_select_pin_i,
    input wire logic host_bit_clock_i,
    input wire logic host_serial_in_i,
    input wire logic host_serial_out_i,
    output logic host_serial_out_o,
    output logic host_serial_out_oe_o,
    input wire logic addr_strap_bit1_i,
    input wire logic emphasis_strap_pin_i,
    input wire logic [7:0] irq_src_a_i,
    input wire logic [7:0] irq_src_b_i,
    input wire logic [7:0] rx_cs_summary_i,
    input wire logic [7:0] rx_error_flags_i,
    input wire logic [79:0] subcode_q_i,
    input wire logic [7:0] clock_ratio_i,
    output logic [7:0] general_control_o,
    output logic [7:0] mono_hold_control_o,
    output logic [7:0] datapath_routing_o,
    output logic [7:0] clock_source_select_o,
    output logic [7:0] serial_in_format_o,
    output logic [7:0] serial_out_format_o,
    output logic [7:0] rx_error_mask_o,
    output logic spi_mode_o,
    output logic irq_pin_o,
    output logic irq_pin_oe_o
);
    import ctrl_port_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [N_PINS-1:0] pins;
    logic [N_PINS-1:0] meta_r;
    logic [N_PINS-1:0] sync_r;
    logic [N_PINS-1:0] last_r;

    assign pins = {emphasis_strap_pin_i, addr_strap_bit1_i, host_serial_out_i,
                   host_serial_in_i, host_bit_clock_i, mode_strap_select_pin_i};

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // ****************************************
    // strap capture and mode select
    // ****************************************
    logic [1:0] settle_r;
    logic armed;
    logic emphasis_strap_pin_r;
    logic spi_mode_r;
    logic sel_fall;
    logic spi_now;

    assign armed = (settle_r == STRAP_SETTLE);
    assign sel_fall = last_r[P_SEL] & ~sync_r[P_SEL];
    assign spi_now = spi_mode_r | (armed & sel_fall);

    // emphasis level taken once the synchroniser has filled after release
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle_r <= 2'h0;
            emphasis_strap_pin_r <= 1'b0;
        end else if (!armed) begin
            settle_r <= settle_r + 2'h1;
            emphasis_strap_pin_r <= sync_r[P_EMPHASIS_STRAP_PIN];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            spi_mode_r <= 1'b0;
        end else if (armed && sel_fall) begin
            spi_mode_r <= 1'b1;
        end
    end

    // ****************************************
    // frame events
    // ****************************************
    logic clk_rise;
    logic clk_fall;
    logic din;
    logic start_ev;
    logic stop_ev;
    logic [6:0] my_addr;

    assign clk_rise = sync_r[P_CLK] & ~last_r[P_CLK];
    assign clk_fall = ~sync_r[P_CLK] & last_r[P_CLK];
    assign din = spi_now ? sync_r[P_DIN] : sync_r[P_SDA];
    assign start_ev = spi_now ? sel_fall
        : (sync_r[P_CLK] & last_r[P_CLK] & last_r[P_SDA] & ~sync_r[P_SDA]);
    assign stop_ev = spi_now ? sync_r[P_SEL]
        : (sync_r[P_CLK] & last_r[P_CLK] & ~last_r[P_SDA] & sync_r[P_SDA]);
    // strap pin doubles as address bit0 while it stays static
    assign my_addr = spi_now ? SPI_CHIP_ADDR
        : {I2C_ADDR_UPPER, emphasis_strap_pin_r, sync_r[P_AD1], sync_r[P_SEL]};

    // ****************************************
    // receive state machine
    // ****************************************
    state_t state_r;
    logic [3:0] bit_r;
    logic [6:0] rx_sh_r;
    logic [7:0] ptr_r;
    logic ack_r;
    logic [7:0] rx_byte;
    logic rx_edge;
    logic byte_done;
    logic ack_edge;
    logic wr_stb;
    logic [7:0] ptr_step;

    assign rx_byte = {rx_sh_r, din};
    assign ack_edge = clk_rise & ~stop_ev & ~start_ev & (state_r != ST_IDLE)
                      & ~spi_now & (bit_r == ACK_BIT);
    assign rx_edge = clk_rise & ~stop_ev & ~start_ev & (state_r != ST_IDLE) & ~ack_edge;
    assign byte_done = rx_edge & (bit_r == LAST_BIT);
    assign wr_stb = byte_done & (state_r == ST_WDATA);
    assign ptr_step = ptr_r[PTR_STEP_BIT]
        ? {ptr_r[7], ptr_r[6:0] + 7'h01} : ptr_r;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            rx_sh_r <= 7'h00;
            ptr_r <= PTR_RESET;
            ack_r <= 1'b0;
        end else if (stop_ev) begin
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            ack_r <= 1'b0;
        end else if (start_ev) begin
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
            ack_r <= 1'b0;
        end else if (ack_edge) begin
            bit_r <= 4'h0;
            ack_r <= 1'b0;
            if (state_r == ST_RDATA && din) begin
                state_r <= ST_IGNORE;
            end
        end else if (rx_edge) begin
            rx_sh_r <= rx_byte[6:0];
            if (bit_r != LAST_BIT) begin
                bit_r <= bit_r + 4'h1;
            end else begin
                bit_r <= spi_now ? 4'h0 : ACK_BIT;
                unique case (state_r)
                    ST_ADDR: begin
                        if (rx_byte[7:1] == my_addr) begin
                            state_r <= rx_byte[0] ? ST_RDATA : ST_PTR;
                            ack_r <= 1'b1;
                        end else begin
                            state_r <= ST_IGNORE;
                        end
                    end
                    ST_PTR: begin
                        ptr_r <= rx_byte;
                        state_r <= ST_WDATA;
                        ack_r <= 1'b1;
                    end
                    ST_WDATA: begin
                        ptr_r <= ptr_step;
                        ack_r <= 1'b1;
                    end
                    ST_RDATA: ptr_r <= ptr_step;
                    ST_IDLE, ST_IGNORE: ;
                endcase
            end
        end
    end

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] regs_r [0:127];

    // non-writable and reserved addresses give a zero mask, so writes vanish
    function automatic logic [7:0] wmask(input logic [6:0] a);
        if (a >= REG_BUF_FIRST && a <= REG_BUF_LAST) begin
            return WM_FULL;
        end
        unique case (a)
            REG_GENERAL: return WM_GENERAL;
            REG_MONO, REG_CLKSRC, REG_RX_ERR_MASK: return WM_SEVEN;
            REG_ROUTING: return WM_ROUTING;
            REG_SIN_FMT, REG_SOUT_FMT: return WM_FULL;
            REG_MASK_A, REG_MODE_HI_A, REG_MODE_LO_A: return WM_IRQ_A;
            REG_MASK_B, REG_MODE_HI_B, REG_MODE_LO_B: return WM_IRQ_B;
            REG_CS_BUF_CTL: return WM_CS_BUF;
            REG_U_BUF_CTL: return WM_U_BUF;
            default: return 8'h00;
        endcase
    endfunction

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 128; i++) begin
                regs_r[i] <= 8'h00;
            end
            regs_r[REG_ROUTING] <= RST_ROUTING;
        end else if (wr_stb) begin
            regs_r[ptr_r[6:0]] <= rx_byte & wmask(ptr_r[6:0]);
        end
    end

    // ****************************************
    // interrupt status and pin
    // ****************************************
    logic [7:0] prev_a_r;
    logic [7:0] prev_b_r;
    logic [7:0] stick_a_r;
    logic [7:0] stick_b_r;
    logic [7:0] sta_a;
    logic [7:0] sta_b;
    logic [7:0] hi_a;
    logic [7:0] lo_a;
    logic [7:0] hi_b;
    logic [7:0] lo_b;
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic clr_a;
    logic clr_b;
    logic irq_act;
    logic [1:0] style;

    assign hi_a = regs_r[REG_MODE_HI_A];
    assign lo_a = regs_r[REG_MODE_LO_A];
    assign hi_b = regs_r[REG_MODE_HI_B];
    assign lo_b = regs_r[REG_MODE_LO_B];
    // mode 00 rising, 01 falling, 1x level
    assign ev_a = ~hi_a & ((~lo_a & irq_src_a_i & ~prev_a_r)
                         | (lo_a & ~irq_src_a_i & prev_a_r));
    assign ev_b = ~hi_b & ((~lo_b & irq_src_b_i & ~prev_b_r)
                         | (lo_b & ~irq_src_b_i & prev_b_r));
    assign sta_a = ((hi_a & irq_src_a_i) | (~hi_a & stick_a_r)) & WM_IRQ_A;
    assign sta_b = ((hi_b & irq_src_b_i) | (~hi_b & stick_b_r)) & WM_IRQ_B;

    // a new edge in the clearing cycle survives the read
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_a_r <= 8'h00;
            prev_b_r <= 8'h00;
            stick_a_r <= 8'h00;
            stick_b_r <= 8'h00;
        end else begin
            prev_a_r <= irq_src_a_i;
            prev_b_r <= irq_src_b_i;
            stick_a_r <= (clr_a ? 8'h00 : stick_a_r) | ev_a;
            stick_b_r <= (clr_b ? 8'h00 : stick_b_r) | ev_b;
        end
    end

    assign irq_act = |(sta_a & regs_r[REG_MASK_A]) | |(sta_b & regs_r[REG_MASK_B]);
    assign style = regs_r[REG_GENERAL][STYLE_LSB +: 2];

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_pin_o <= 1'b0;
            irq_pin_oe_o <= 1'b1;
        end else begin
            unique case (style)
                STYLE_LOW: begin
                    irq_pin_o <= ~irq_act;
                    irq_pin_oe_o <= 1'b1;
                end
                STYLE_OPEN: begin
                    irq_pin_o <= 1'b0;
                    irq_pin_oe_o <= irq_act;
                end
                default: begin
                    // reserved code behaves as active high
                    irq_pin_o <= irq_act;
                    irq_pin_oe_o <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // read data and transmit
    // ****************************************
    logic [7:0] rd_val;
    logic [6:0] ra;
    logic [6:0] sub_idx;
    logic tx_edge;
    logic tx_load;
    logic [7:0] tx_sh_r;
    logic sdo_r;
    logic sdo_oe_r;

    assign ra = ptr_r[6:0];
    assign sub_idx = ra - REG_SUBCODE_FIRST;

    always_comb begin
        rd_val = 8'h00;
        if (ra >= REG_SUBCODE_FIRST && ra <= REG_SUBCODE_LAST) begin
            rd_val = subcode_q_i[sub_idx[3:0]*8 +: 8];
        end else if (wmask(ra) != 8'h00) begin
            rd_val = regs_r[ra];
        end else begin
            unique case (ra)
                REG_STA_A: rd_val = sta_a;
                REG_STA_B: rd_val = sta_b;
                REG_RX_CS: rd_val = rx_cs_summary_i;
                REG_RX_ERR: rd_val = rx_error_flags_i;
                REG_CLK_RATIO: rd_val = clock_ratio_i;
                REG_IDENTITY: rd_val = ID_VALUE;
                default: rd_val = 8'h00;
            endcase
        end
    end

    assign tx_edge = clk_fall & ~stop_ev & ~start_ev & (state_r != ST_IDLE);
    assign tx_load = tx_edge & (state_r == ST_RDATA) & (bit_r == 4'h0);
    assign clr_a = tx_load & (ra == REG_STA_A);
    assign clr_b = tx_load & (ra == REG_STA_B);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_sh_r <= 8'h00;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (stop_ev || start_ev) begin
            sdo_oe_r <= 1'b0;
        end else if (tx_edge) begin
            if (tx_load) begin
                tx_sh_r <= {rd_val[6:0], 1'b0};
            end else if (state_r == ST_RDATA && bit_r != ACK_BIT) begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
            if (spi_now) begin
                sdo_r <= tx_load ? rd_val[7] : tx_sh_r[7];
                sdo_oe_r <= (state_r == ST_RDATA);
            end else begin
                sdo_r <= 1'b0;
                if (bit_r == ACK_BIT) begin
                    sdo_oe_r <= ack_r;
                end else if (state_r == ST_RDATA) begin
                    sdo_oe_r <= tx_load ? ~rd_val[7] : ~tx_sh_r[7];
                end else begin
                    sdo_oe_r <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign host_serial_out_o = sdo_r;
    assign host_serial_out_oe_o = sdo_oe_r;
    assign spi_mode_o = spi_mode_r;
    assign general_control_o = regs_r[REG_GENERAL];
    assign mono_hold_control_o = regs_r[REG_MONO];
    assign datapath_routing_o = regs_r[REG_ROUTING];
    assign clock_source_select_o = regs_r[REG_CLKSRC];
    assign serial_in_format_o = regs_r[REG_SIN_FMT];
    assign serial_out_format_o = regs_r[REG_SOUT_FMT];
    assign rx_error_mask_o = regs_r[REG_RX_ERR_MASK];
endmodule

//--- tb/spi_host_model.sv
// Purpose: host microcontroller acting as SPI master on the control port
// Assumes: bit clock of 160 ns, 16 mclk per bit, idle low
// Notes: frames are built by the testbench from start, xbyte and stop
`timescale 1ns/1ps
module spi_host_model (
    input wire logic mclk_i,
    input wire logic miso_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // ********************************
    // bit timing
    // ********************************
    task automatic half();
        repeat (8) @(negedge mclk_i);
    endtask
    task automatic start();
        cs_n_o = 1'b0;
        half();
    endtask
    // clock stands still and data holds between frames
    task automatic stop();
        half();
        cs_n_o = 1'b1;
        half();
        half();
    endtask
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            half();
            sclk_o = 1'b1;
            rx[i] = miso_i;
            half();
            sclk_o = 1'b0;
        end
    endtask
endmodule

//--- tb/dual_mode_control_port_properties.sv
// Purpose: port-level checks of the dual mode control port
// Assumes: SPI selected once per run, style field in bits 2:1
// Notes: bound into every instance of the port
`timescale 1ns/1ps
module ctrl_port_properties (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic mode_strap_select_pin_i,
    input wire logic host_bit_clock_i,
    input wire logic host_serial_out_o,
    input wire logic host_serial_out_oe_o,
    input wire logic [7:0] general_control_o,
    input wire logic spi_mode_o,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe_o
);
    import ctrl_port_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // ********************************
    // serial port
    // ********************************
    a_spi_mode_sticky: assert property (!$fell(spi_mode_o))
        else $error("spi mode dropped");
    a_spi_select_low: assert property ($rose(spi_mode_o) |-> !mode_strap_select_pin_i)
        else $error("spi mode without select low");
    a_drive_on_fall: assert property ($rose(host_serial_out_oe_o) && spi_mode_o
        |-> !host_bit_clock_i && !mode_strap_select_pin_i)
        else $error("serial out enabled outside low clock phase");
    a_shift_on_fall: assert property (spi_mode_o && host_serial_out_oe_o
        && $past(host_serial_out_oe_o) && $changed(host_serial_out_o)
        |-> !host_bit_clock_i)
        else $error("serial out changed in high clock phase");
    a_release_at_deselect: assert property (spi_mode_o && mode_strap_select_pin_i[*6]
        |-> !host_serial_out_oe_o)
        else $error("serial out driven while deselected");
    // ********************************
    // interrupt pin
    // ********************************
    a_style_high_drive: assert property ((general_control_o[2:1] == STYLE_HIGH)[*2]
        |-> irq_pin_oe_o)
        else $error("push pull high style not driving");
    a_style_low_drive: assert property ((general_control_o[2:1] == STYLE_LOW)[*2]
        |-> irq_pin_oe_o)
        else $error("push pull low style not driving");
    a_open_drain_low: assert property ((general_control_o[2:1] == STYLE_OPEN)[*2]
        |-> !irq_pin_o)
        else $error("open drain style drives high");
endmodule
bind dual_mode_control_port ctrl_port_properties chk_u (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .mode_strap_select_pin_i(mode_strap_select_pin_i),
    .host_bit_clock_i(host_bit_clock_i),
    .host_serial_out_o(host_serial_out_o),
    .host_serial_out_oe_o(host_serial_out_oe_o),
    .general_control_o(general_control_o),
    .spi_mode_o(spi_mode_o),
    .irq_pin_o(irq_pin_o),
    .irq_pin_oe_o(irq_pin_oe_o)
);

//--- tb/dual_mode_control_port_tb.sv
// Purpose: register access tests of the control port in SPI mode
// Assumes: strap pin idles high, first select falls well after reset
// Notes: released serial out line shows the inverse of its last value
`timescale 1ns/1ps
module dual_mode_control_port_tb;
    import ctrl_port_pkg::*;
    logic mclk_i, arst_n_i, cs_n, sclk, mosi, sout, sout_oe, last_r, line;
    logic write_phase, oe_seen, spi_mode, irq_o, irq_oe;
    logic [7:0] src_a, rx_err, ratio, gc, mono, route, clksrc, sin_f, sout_f, rxmask, r0, r1;
    logic [7:0] cs_sum;
    logic [79:0] subq;
    int bad_count, compares;
    assign line = sout_oe ? sout : ~last_r;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_r <= 1'b0;
            oe_seen <= 1'b0;
        end else begin
            if (sout_oe) last_r <= sout;
            if (write_phase && sout_oe) oe_seen <= 1'b1;
        end
    end
    dual_mode_control_port #(.ID_VALUE(8'h5A)) dut_u ( // arbitrary value
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .mode_strap_select_pin_i(cs_n),
        .host_bit_clock_i(sclk), .host_serial_in_i(mosi), .host_serial_out_i(line),
        .host_serial_out_o(sout), .host_serial_out_oe_o(sout_oe),
        .addr_strap_bit1_i(1'b0), .emphasis_strap_pin_i(1'b0),
        .irq_src_a_i(src_a), .irq_src_b_i(8'h00), .rx_cs_summary_i(cs_sum),
        .rx_error_flags_i(rx_err), .subcode_q_i(subq), .clock_ratio_i(ratio),
        .general_control_o(gc), .mono_hold_control_o(mono), .datapath_routing_o(route),
        .clock_source_select_o(clksrc), .serial_in_format_o(sin_f),
        .serial_out_format_o(sout_f), .rx_error_mask_o(rxmask), .spi_mode_o(spi_mode),
        .irq_pin_o(irq_o), .irq_pin_oe_o(irq_oe)
    );
    spi_host_model host_u (.mclk_i(mclk_i), .miso_i(line), .cs_n_o(cs_n), .sclk_o(sclk),
        .mosi_o(mosi));
    // ********************************
    // shared tasks
    // ********************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] chip, input logic [7:0] ptr, input int n,
        input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
        logic [7:0] dummy;
        logic [7:0] d [3];
        d = '{d0, d1, d2};
        write_phase = 1'b1;
        host_u.start();
        host_u.xbyte({chip, 1'b0}, dummy);
        host_u.xbyte(ptr, dummy);
        for (int i = 0; i < n; i++) host_u.xbyte(d[i], dummy);
        host_u.stop();
        write_phase = 1'b0;
    endtask
    // pointer loaded by a partial write, then a two-byte read frame
    task automatic rd(input logic [7:0] ptr, output logic [7:0] a, output logic [7:0] b);
        logic [7:0] dummy;
        wr(SPI_CHIP_ADDR, ptr, 0, 8'h00, 8'h00, 8'h00);
        host_u.start();
        host_u.xbyte({SPI_CHIP_ADDR, 1'b1}, dummy);
        host_u.xbyte(8'h00, a);
        host_u.xbyte(8'h00, b);
        host_u.stop();
    endtask
    // ********************************
    // clock, watchdog, tests
    // ********************************
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // about 70 bytes of 1.3 us each; generous margin
    initial begin
        #500000;
        bad_count++;
        complete_run();
    end
    initial begin
        arst_n_i = 1'b0;
        src_a = 8'h00;
        rx_err = 8'h55;
        ratio = 8'hC3;
        write_phase = 1'b0;
        cs_sum = 8'hB4;
        subq = 80'h1E69;
        bad_count = 0;
        compares = 0;
        repeat (3) @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (10) @(negedge mclk_i);
        check("routing_reset", route, RST_ROUTING);
        check("general_reset", gc, 8'h00);
        check("spi_mode_reset", {7'h00, spi_mode}, 8'h00);
        wr(SPI_CHIP_ADDR, 8'h01, 1, 8'h04, 8'h00, 8'h00);
        check("spi_mode", {7'h00, spi_mode}, 8'h01);
        check("general_write", gc, 8'h04 & WM_GENERAL);
        check("irq_open_idle", {7'h00, irq_oe}, 8'h00);
        wr(SPI_CHIP_ADDR, 8'h85, 2, 8'hA5, 8'h3C, 8'h00);
        check("in_format", sin_f, 8'hA5);
        check("out_format", sout_f, 8'h3C);
        wr(SPI_CHIP_ADDR, 8'h02, 2, 8'h11, 8'h22, 8'h00);
        check("mono_fixed", mono, 8'h22 & WM_SEVEN);
        check("routing_kept", route, RST_ROUTING);
        wr(7'h11, 8'h01, 1, 8'hFF, 8'h00, 8'h00);
        check("general_kept", gc, 8'h04 & WM_GENERAL);
        check("oe_in_writes", {7'h00, oe_seen}, 8'h00);
        rd(8'h85, r0, r1);
        check("read_first", r0, 8'hA5);
        check("read_stepped", r1, 8'h3C);
        rd(8'h10, r0, r1);
        check("read_errors", r0, 8'h55);
        check("read_fixed", r1, 8'h55);
        rd(8'h1E, r0, r1);
        check("read_ratio", r0, 8'hC3);
        rd(8'h7F, r0, r1);
        check("read_identity", r0, 8'h5A);
        rd(8'h0F, r0, r1);
        check("read_cs_summary", r0, 8'hB4);
        rd(8'h94, r0, r1);
        check("read_subcode_lo", r0, 8'h69);
        check("read_subcode_hi", r1, 8'h1E);
        wr(SPI_CHIP_ADDR, 8'h04, 1, 8'hFF, 8'h00, 8'h00);
        check("clock_source", clksrc, 8'hFF & WM_SEVEN);
        wr(SPI_CHIP_ADDR, 8'h11, 1, 8'hFF, 8'h00, 8'h00);
        check("error_mask", rxmask, 8'hFF & WM_SEVEN);
        wr(SPI_CHIP_ADDR, 8'h01, 1, 8'h00, 8'h00, 8'h00);
        wr(SPI_CHIP_ADDR, 8'h89, 3, 8'h01, 8'h00, 8'h00);
        src_a = 8'h01;
        repeat (10) @(negedge mclk_i);
        check("irq_rise_high", {irq_oe, irq_o}, 8'h03);
        wr(SPI_CHIP_ADDR, 8'h09, 1, 8'h00, 8'h00, 8'h00);
        check("irq_masked", {irq_oe, irq_o}, 8'h02);
        wr(SPI_CHIP_ADDR, 8'h01, 1, 8'h02, 8'h00, 8'h00);
        check("irq_low_idle", {irq_oe, irq_o}, 8'h03);
        wr(SPI_CHIP_ADDR, 8'h01, 1, 8'h04, 8'h00, 8'h00);
        check("irq_open_off", {7'h00, irq_oe}, 8'h00);
        wr(SPI_CHIP_ADDR, 8'h09, 1, 8'h01, 8'h00, 8'h00);
        check("irq_open_on", {irq_oe, irq_o}, 8'h02);
        complete_run();
    end
endmodule
